// ### hdl/fcs_pkg.sv
package fcs_pkg;

	// serial register port framing: read flag, 7-bit address, 16-bit data, msb first
	localparam int               ADDR_W         = 7;
	localparam int               DATA_W         = 16;
	localparam logic [4:0]       ADDR_LAST_BIT  = 5'h07;
	localparam logic [4:0]       FRAME_LAST_BIT = 5'h17;

	// register map
	localparam logic [6:0]       ADDR_BANK_SEL   = 7'h01;
	localparam logic [6:0]       ADDR_CRC_RESULT = 7'h05;
	localparam logic [6:0]       ADDR_FUSE_READY = 7'h5A;
	localparam logic [6:0]       ADDR_TEST_MODE  = 7'h5D;

	// bank select codes
	localparam int               BANK_W      = 3;
	localparam logic [2:0]       BANK_CHAN_D = 3'h3;
	localparam logic [2:0]       BANK_ALL    = 3'h4;
	localparam logic [2:0]       BANK_MASTER = 3'h7;
	localparam logic [2:0]       BANK_SEL_RST = 3'h0;

	// field positions
	localparam int               CRC_MASTER_BIT   = 7;
	localparam int               CRC_CHAN_A_BIT   = 3;
	localparam int               MASTER_READY_BIT = 0;
	localparam int               TEST_ENA_BIT     = 0;
	localparam logic [15:0]      TEST_MODE_RST    = 16'h0000;

	// fuse array: banks 0..3 are channels a..d, bank 4 is the master bank
	localparam int               NUM_CHAN    = 4;
	localparam int               NUM_BANK    = 5;
	localparam int               MASTER_IDX  = 4;
	localparam int               ROM_AW      = 6;
	localparam logic [5:0]       ROM_LAST    = 6'h27;
	localparam logic [2:0]       WORD_REF_IDX = 3'h7;
	localparam logic [15:0]      CRC_POLY    = 16'h1021;
	localparam logic [15:0]      CRC_SEED    = 16'hFFFF;

	// timing
	localparam int               CLK_MHZ        = 100;
	localparam int               CRC_DONE_CYC   = 4500;
	localparam int               READY_TIME_US  = 1000;
	localparam int               READY_CYC      = READY_TIME_US * CLK_MHZ;
	localparam int               READY_CNT_W    = 20;
	localparam int               RESET_MIN_US   = 10;

	// sample path
	localparam int               SMP_W = 12;

	typedef struct packed {
		logic             over_range;
		logic [SMP_W-1:0] data;
	} fcs_sample_t;

	typedef enum logic [2:0] {
		CRC_IDLE       = 3'b000,
		CRC_WAIT_READY = 3'b001,
		CRC_READ       = 3'b010,
		CRC_DRAIN      = 3'b011,
		CRC_DONE       = 3'b100
	} fcs_crc_state_t;

	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [15:0] word);
		logic [15:0] c;
		c = crc;
		for (int i = 15; i >= 0; i--) begin
			if (c[15] ^ word[i]) begin
				c = {c[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		return c;
	endfunction

	// fuse contents are a fixed arbitrary pattern
	function automatic logic [15:0] fuse_data(input logic [5:0] addr);
		return {addr, 10'h000} ^ 16'h5A3C ^ {10'h000, addr};
	endfunction

	function automatic logic [15:0] ref_crc(input logic [2:0] bank);
		logic [15:0] c;
		c = CRC_SEED;
		for (int i = 0; i < 7; i++) begin
			c = crc16_step(c, fuse_data({bank, 3'(i)}));
		end
		return c;
	endfunction

endpackage

// ### hdl/fcs_fuse_rom.sv
`timescale 1ns/1ps
module fcs_fuse_rom (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_b,
	input  wire logic [fcs_pkg::ROM_AW-1:0] rd_addr,
	input  wire logic                       defect,
	output logic      [15:0]                rd_data_q
);

	logic [15:0] word;
	logic [15:0] rd_data_d;

	// last word of each bank holds the reference crc burnt at manufacture
	always_comb begin
		if (rd_addr[2:0] == fcs_pkg::WORD_REF_IDX) begin
			word = fcs_pkg::ref_crc(rd_addr[5:3]);
		end else begin
			word = fcs_pkg::fuse_data(rd_addr);
		end
		rd_data_d = {word[15:1], word[0] ^ defect};
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rd_data_q <= 16'h0000;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

endmodule // fcs_fuse_rom

// ### hdl/fcs_top.sv
`timescale 1ns/1ps
module fcs_top #(
	parameter int READY_CYC = fcs_pkg::READY_CYC
) (
	input  wire logic                                  clk_sys,
	input  wire logic                                  rst_b,
	input  wire logic                                  reset_pin_low_active,
	input  wire logic                                  spi_sclk,
	input  wire logic                                  spi_cs_b,
	input  wire logic                                  spi_mosi,
	output logic                                       spi_miso,
	output logic                                       spi_miso_oe,
	input  wire logic [fcs_pkg::NUM_BANK-1:0]          fuse_defect_mask,
	input  fcs_pkg::fcs_sample_t [fcs_pkg::NUM_CHAN-1:0] chan_sample_in,
	output logic [fcs_pkg::NUM_CHAN-1:0][fcs_pkg::SMP_W-1:0] chan_data_out,
	output logic [fcs_pkg::NUM_CHAN-1:0]               chan_parity_out,
	output logic                                       chan_a_in_range_out,
	output logic                                       chan_b_in_range_out,
	output logic                                       chan_c_in_range_out,
	output logic                                       chan_d_in_range_out
);

	function automatic logic bank_is_chan(input logic [2:0] bank);
		return bank <= fcs_pkg::BANK_CHAN_D;
	endfunction

	// ---------------- synchronisers for pins
	logic                          sclk_s1, sclk_s2, sclk_s3;
	logic                          cs_b_s1, cs_b_s2;
	logic                          mosi_s1, mosi_s2;
	logic                          rpin_s1, rpin_s2;
	logic [fcs_pkg::NUM_BANK-1:0]  defect_s1, defect_s2;

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			sclk_s1   <= 1'b0;
			sclk_s2   <= 1'b0;
			sclk_s3   <= 1'b0;
			cs_b_s1   <= 1'b1;
			cs_b_s2   <= 1'b1;
			mosi_s1   <= 1'b0;
			mosi_s2   <= 1'b0;
			rpin_s1   <= 1'b0;
			rpin_s2   <= 1'b0;
			defect_s1 <= '0;
			defect_s2 <= '0;
		end else begin
			sclk_s1   <= spi_sclk;
			sclk_s2   <= sclk_s1;
			sclk_s3   <= sclk_s2;
			cs_b_s1   <= spi_cs_b;
			cs_b_s2   <= cs_b_s1;
			mosi_s1   <= spi_mosi;
			mosi_s2   <= mosi_s1;
			rpin_s1   <= reset_pin_low_active;
			rpin_s2   <= rpin_s1;
			defect_s1 <= fuse_defect_mask;
			defect_s2 <= defect_s1;
		end
	end

	// the reset pin clears the register port, registers, wake-up timer and crc engine; the sample path resets on the system reset only
	logic dig_rst;
	assign dig_rst = !rst_b || !rpin_s2;

	logic sclk_rise, sclk_fall;
	assign sclk_rise = sclk_s2 && !sclk_s3 && !cs_b_s2;
	assign sclk_fall = !sclk_s2 && sclk_s3 && !cs_b_s2;

	// ---------------- status state read by the register port
	logic [fcs_pkg::NUM_BANK-1:0]  ready_q;
	logic [fcs_pkg::NUM_BANK-1:0]  pass_q;
	logic [2:0]                    bank_sel_q;
	logic [15:0]                   test_mode_q;

	function automatic logic [15:0] read_word(input logic [6:0] addr);
		logic [15:0] w;
		w = 16'h0000;
		case (addr)
			fcs_pkg::ADDR_BANK_SEL:   w = {13'h0000, bank_sel_q};
			fcs_pkg::ADDR_TEST_MODE:  w = test_mode_q;
			fcs_pkg::ADDR_CRC_RESULT: begin
				if (bank_sel_q == fcs_pkg::BANK_MASTER) begin
					w[fcs_pkg::CRC_MASTER_BIT] = pass_q[fcs_pkg::MASTER_IDX];
					w[fcs_pkg::CRC_CHAN_A_BIT +: fcs_pkg::NUM_CHAN] = pass_q[fcs_pkg::NUM_CHAN-1:0];
					w[fcs_pkg::MASTER_READY_BIT] = ready_q[fcs_pkg::MASTER_IDX];
				end
			end
			fcs_pkg::ADDR_FUSE_READY: begin
				if (bank_is_chan(bank_sel_q)) begin
					w[0] = ready_q[bank_sel_q[1:0]];
				end
			end
			default: w = 16'h0000;
		endcase
		return w;
	endfunction

	// ---------------- serial register port
	logic [4:0]  bit_cnt_q, bit_cnt_d;
	logic [23:0] sh_in_q, sh_in_d;
	logic [15:0] sh_out_q, sh_out_d;
	logic [6:0]  addr_q, addr_d;
	logic        rd_q, rd_d;
	logic        miso_q, miso_d;
	logic        oe_q, oe_d;
	logic        wr_en;
	logic [15:0] wr_data;

	always_comb begin
		bit_cnt_d = bit_cnt_q;
		sh_in_d   = sh_in_q;
		sh_out_d  = sh_out_q;
		addr_d    = addr_q;
		rd_d      = rd_q;
		miso_d    = miso_q;
		oe_d      = oe_q;
		wr_en     = 1'b0;
		wr_data   = {sh_in_q[14:0], mosi_s2};
		if (cs_b_s2) begin
			bit_cnt_d = 5'h00;
			oe_d      = 1'b0;
			miso_d    = 1'b0;
		end else if (sclk_rise) begin
			sh_in_d   = {sh_in_q[22:0], mosi_s2};
			bit_cnt_d = bit_cnt_q + 5'h01;
			if (bit_cnt_q == fcs_pkg::ADDR_LAST_BIT) begin
				addr_d = {sh_in_q[5:0], mosi_s2};
				rd_d   = sh_in_q[6];
				if (sh_in_q[6]) begin
					sh_out_d = read_word({sh_in_q[5:0], mosi_s2});
					oe_d     = 1'b1;
				end
			end
			if (bit_cnt_q == fcs_pkg::FRAME_LAST_BIT) begin
				wr_en     = !rd_q;
				bit_cnt_d = 5'h00;
			end
		end else if (sclk_fall && oe_q) begin
			miso_d   = sh_out_q[15];
			sh_out_d = {sh_out_q[14:0], 1'b0};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dig_rst) begin
			bit_cnt_q <= 5'h00;
			sh_in_q   <= 24'h000000;
			sh_out_q  <= 16'h0000;
			addr_q    <= 7'h00;
			rd_q      <= 1'b0;
			miso_q    <= 1'b0;
			oe_q      <= 1'b0;
		end else begin
			bit_cnt_q <= bit_cnt_d;
			sh_in_q   <= sh_in_d;
			sh_out_q  <= sh_out_d;
			addr_q    <= addr_d;
			rd_q      <= rd_d;
			miso_q    <= miso_d;
			oe_q      <= oe_d;
		end
	end

	assign spi_miso    = miso_q;
	assign spi_miso_oe = oe_q;

	// ---------------- writable registers; status addresses have no write path
	logic [2:0]  bank_sel_d;
	logic [15:0] test_mode_d;
	logic        test_start;

	always_comb begin
		bank_sel_d  = bank_sel_q;
		test_mode_d = test_mode_q;
		test_start  = 1'b0;
		if (wr_en) begin
			case (addr_q)
				fcs_pkg::ADDR_BANK_SEL: bank_sel_d = wr_data[2:0];
				fcs_pkg::ADDR_TEST_MODE: begin
					// test mode is written only with a channel bank or the all-banks code selected
					if (bank_is_chan(bank_sel_q) || bank_sel_q == fcs_pkg::BANK_ALL) begin
						test_mode_d = wr_data;
						test_start  = wr_data[fcs_pkg::TEST_ENA_BIT] && !test_mode_q[fcs_pkg::TEST_ENA_BIT];
					end
				end
				default: bank_sel_d = bank_sel_q;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dig_rst) begin
			bank_sel_q  <= fcs_pkg::BANK_SEL_RST;
			test_mode_q <= fcs_pkg::TEST_MODE_RST;
		end else begin
			bank_sel_q  <= bank_sel_d;
			test_mode_q <= test_mode_d;
		end
	end

	// ---------------- fuse wake-up timer
	logic [fcs_pkg::READY_CNT_W-1:0] ready_cnt_q, ready_cnt_d;
	logic [fcs_pkg::NUM_BANK-1:0]    ready_d;

	always_comb begin
		ready_cnt_d = ready_cnt_q;
		ready_d     = ready_q;
		if (ready_cnt_q == fcs_pkg::READY_CNT_W'(READY_CYC - 1)) begin
			ready_d = '1;
		end else begin
			ready_cnt_d = ready_cnt_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dig_rst) begin
			ready_cnt_q <= '0;
			ready_q     <= '0;
		end else begin
			ready_cnt_q <= ready_cnt_d;
			ready_q     <= ready_d;
		end
	end

	// ---------------- crc check engine
	fcs_pkg::fcs_crc_state_t   st_q, st_d;
	logic [fcs_pkg::ROM_AW-1:0] raddr_q, raddr_d;
	logic [fcs_pkg::ROM_AW-1:0] vaddr_q, vaddr_d;
	logic                      vld_q, vld_d;
	logic [15:0]               crc_q, crc_d;
	logic [fcs_pkg::NUM_BANK-1:0] pass_d;
	logic [15:0]               rom_data;

	fcs_fuse_rom u_rom (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.rd_addr   (raddr_q),
		.defect    (defect_s2[raddr_q[5:3]]),
		.rd_data_q (rom_data)
	);

	// one word per cycle: the whole check takes about 43 cycles, far inside the 4500 budget
	always_comb begin
		st_d    = st_q;
		raddr_d = raddr_q;
		vaddr_d = raddr_q;
		vld_d   = 1'b0;
		crc_d   = crc_q;
		pass_d  = pass_q;
		case (st_q)
			fcs_pkg::CRC_IDLE: begin
				if (test_start) begin
					st_d   = fcs_pkg::CRC_WAIT_READY;
					pass_d = '0;
				end
			end
			fcs_pkg::CRC_WAIT_READY: begin
				raddr_d = '0;
				crc_d   = fcs_pkg::CRC_SEED;
				if (&ready_q) begin
					st_d = fcs_pkg::CRC_READ;
				end
			end
			fcs_pkg::CRC_READ: begin
				vld_d = 1'b1;
				if (raddr_q == fcs_pkg::ROM_LAST) begin
					st_d = fcs_pkg::CRC_DRAIN;
				end else begin
					raddr_d = raddr_q + 1'b1;
				end
			end
			fcs_pkg::CRC_DRAIN: begin
				if (!vld_q) begin
					st_d = fcs_pkg::CRC_DONE;
				end
			end
			fcs_pkg::CRC_DONE: begin
				if (test_start) begin
					st_d   = fcs_pkg::CRC_WAIT_READY;
					pass_d = '0;
				end
			end
			default: st_d = fcs_pkg::CRC_IDLE;
		endcase
		if (vld_q) begin
			if (vaddr_q[2:0] == fcs_pkg::WORD_REF_IDX) begin
				pass_d[vaddr_q[5:3]] = (crc_q == rom_data);
				crc_d = fcs_pkg::CRC_SEED;
			end else begin
				crc_d = fcs_pkg::crc16_step(crc_q, rom_data);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (dig_rst) begin
			st_q    <= fcs_pkg::CRC_IDLE;
			raddr_q <= '0;
			vaddr_q <= '0;
			vld_q   <= 1'b0;
			crc_q   <= fcs_pkg::CRC_SEED;
			pass_q  <= '0;
		end else begin
			st_q    <= st_d;
			raddr_q <= raddr_d;
			vaddr_q <= vaddr_d;
			vld_q   <= vld_d;
			crc_q   <= crc_d;
			pass_q  <= pass_d;
		end
	end

	// ---------------- per-sample output flags
	logic [fcs_pkg::NUM_CHAN-1:0] in_range_q;

	generate
		for (genvar ch = 0; ch < fcs_pkg::NUM_CHAN; ch++) begin : g_chan
			logic [fcs_pkg::SMP_W-1:0] data_d;
			logic                      parity_d;
			logic                      in_range_d;

			always_comb begin
				data_d     = chan_sample_in[ch].data;
				parity_d   = ^chan_sample_in[ch].data;
				in_range_d = !chan_sample_in[ch].over_range;
			end

			// one register stage for word and flags alike keeps them aligned
			always_ff @(posedge clk_sys) begin
				if (!rst_b) begin
					chan_data_out[ch]   <= '0;
					chan_parity_out[ch] <= 1'b0;
					in_range_q[ch]      <= 1'b1;
				end else begin
					chan_data_out[ch]   <= data_d;
					chan_parity_out[ch] <= parity_d;
					in_range_q[ch]      <= in_range_d;
				end
			end
		end
	endgenerate

	assign chan_a_in_range_out = in_range_q[0];
	assign chan_b_in_range_out = in_range_q[1];
	assign chan_c_in_range_out = in_range_q[2];
	assign chan_d_in_range_out = in_range_q[3];

endmodule // fcs_top

// ### tb/fcs_checker.sv
`timescale 1ns/1ps
module fcs_checker #(
	parameter int READY_CYC = fcs_pkg::READY_CYC
) (
	input logic                                         clk_sys,
	input logic                                         rst_b,
	input logic                                         reset_pin_low_active,
	input logic                                         spi_sclk,
	input logic                                         spi_cs_b,
	input logic                                         spi_mosi,
	input logic                                         spi_miso,
	input logic                                         spi_miso_oe,
	input logic [fcs_pkg::NUM_BANK-1:0]                 fuse_defect_mask,
	input fcs_pkg::fcs_sample_t [fcs_pkg::NUM_CHAN-1:0] chan_sample_in,
	input logic [fcs_pkg::NUM_CHAN-1:0][11:0]           chan_data_out,
	input logic [fcs_pkg::NUM_CHAN-1:0]                 chan_parity_out,
	input logic                                         chan_a_in_range_out,
	input logic                                         chan_b_in_range_out,
	input logic                                         chan_c_in_range_out,
	input logic                                         chan_d_in_range_out
);
	logic [3:0] par_in;
	logic [3:0] par_out;
	logic [3:0] over;
	logic [3:0] in_rng;
	logic [3:0][11:0] dat_in;
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			dat_in[c]  = chan_sample_in[c].data;
			par_in[c]  = ^chan_sample_in[c].data;
			par_out[c] = ^chan_data_out[c];
			over[c]    = chan_sample_in[c].over_range;
		end
		in_rng = {chan_d_in_range_out, chan_c_in_range_out, chan_b_in_range_out, chan_a_in_range_out};
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// the edge right after reset still shows the cleared pipeline
	sequence s_run; rst_b && $past(rst_b); endsequence
	// cs_b passes a sync chain, so give it time to land
	sequence s_cs_idle; spi_cs_b [*6]; endsequence
	a_parity_in: assert property (s_run |-> chan_parity_out == $past(par_in)) else $error("parity wrong");
	a_parity_word: assert property (chan_parity_out == par_out) else $error("parity not of word");
	a_data_pipe: assert property (s_run |-> chan_data_out == $past(dat_in)) else $error("data lag");
	a_range_flags: assert property (s_run |-> in_rng == ~$past(over)) else $error("in range wrong");
	a_range_follow: assert property (s_run ##0 $changed(over) |=> $changed(in_rng)) else $error("in range stuck");
	a_reset_clear: assert property ($rose(rst_b) |-> chan_parity_out == 4'h0 && in_rng == 4'hF) else $error("reset state");
	a_oe_in_frame: assert property ($rose(spi_miso_oe) |-> !spi_cs_b) else $error("oe outside frame");
	a_miso_quiet: assert property (s_cs_idle |-> !spi_miso_oe && !spi_miso) else $error("miso driven idle");
endmodule // fcs_checker

bind fcs_top fcs_checker #(.READY_CYC(READY_CYC)) i_chk (.clk_sys, .rst_b, .reset_pin_low_active, .spi_sclk,
	.spi_cs_b, .spi_mosi, .spi_miso, .spi_miso_oe, .fuse_defect_mask, .chan_sample_in, .chan_data_out,
	.chan_parity_out, .chan_a_in_range_out, .chan_b_in_range_out, .chan_c_in_range_out, .chan_d_in_range_out);

// ### tb/fcs_host.sv
`timescale 1ns/1ps
module fcs_host (
	output logic spi_sclk,
	output logic spi_cs_b,
	output logic spi_mosi,
	input  logic spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_b = 1'b1;
		spi_mosi = 1'b0;
	end
	// one 24-bit frame, msb first; sclk parks low between frames
	task automatic frame(input logic rd, input logic [6:0] addr, input logic [15:0] wd, output logic [15:0] rd_q);
		logic [23:0] sh;
		sh = {rd, addr, wd};
		rd_q = 16'h0000;
		spi_cs_b = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			spi_mosi = sh[i];
			#80 spi_sclk = 1'b1;
			if (i < 16) rd_q[i] = spi_miso;
			#80 spi_sclk = 1'b0;
		end
		// released line must not look like a held bit
		spi_mosi = ~spi_mosi;
		#80 spi_cs_b = 1'b1;
		#80;
	endtask
endmodule // fcs_host

// ### tb/fcs_tb_top.sv
`timescale 1ns/1ps
module fcs_tb_top;
	localparam int READY_CYC = 2000;
	logic                       clk_sys = 1'b0;
	logic                       rst_b = 1'b0;
	logic                       reset_pin_low_active = 1'b0;
	logic [4:0]                 fuse_defect_mask = 5'h00;
	fcs_pkg::fcs_sample_t [3:0] chan_sample_in = '0;
	fcs_pkg::fcs_sample_t [3:0] prev;
	logic                       spi_sclk;
	logic                       spi_cs_b;
	logic                       spi_mosi;
	logic                       spi_miso;
	logic [3:0][11:0]           chan_data_out;
	logic [3:0]                 chan_parity_out;
	logic [3:0]                 in_rng;
	logic [15:0]                rdat;
	int                         failures = 0;
	int                         samples_checked = 0;

	always #5 clk_sys = ~clk_sys;

	fcs_top #(.READY_CYC(READY_CYC)) i_dut (.clk_sys, .rst_b, .reset_pin_low_active, .spi_sclk, .spi_cs_b,
		.spi_mosi, .spi_miso, .spi_miso_oe(), .fuse_defect_mask, .chan_sample_in, .chan_data_out,
		.chan_parity_out, .chan_a_in_range_out(in_rng[0]), .chan_b_in_range_out(in_rng[1]),
		.chan_c_in_range_out(in_rng[2]), .chan_d_in_range_out(in_rng[3]));
	fcs_host i_host (.spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		i_host.frame(1'b0, a, d, rdat);
	endtask
	task automatic rd_chk(input string what, input logic [6:0] a, input logic [15:0] exp);
		i_host.frame(1'b1, a, 16'h0000, rdat);
		check(what, rdat, exp);
	endtask
	task automatic results;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#900000;
		failures++;
		$display("[ERR] run expected end seen hang");
		results();
	end

	initial begin
		repeat (6) @(negedge clk_sys);
		rst_b = 1'b1;
		// sample path runs while the reset pin is still low
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			for (int c = 0; c < 4; c++) begin
				if (i > 0) begin
					check("data", 16'(chan_data_out[c]), 16'(prev[c].data));
					check("parity", 16'(chan_parity_out[c]), {15'h0000, ^prev[c].data});
					check("in range", 16'(in_rng[c]), {15'h0000, ~prev[c].over_range});
				end
				chan_sample_in[c].data = 12'(i * 331 + c * 1187);
				chan_sample_in[c].over_range = i[c];
			end
			prev = chan_sample_in;
		end
		repeat (fcs_pkg::RESET_MIN_US * fcs_pkg::CLK_MHZ) @(negedge clk_sys);
		reset_pin_low_active = 1'b1;
		// pin passes a sync chain before the port leaves reset
		repeat (3) @(negedge clk_sys);
		rd_chk("ready early", fcs_pkg::ADDR_FUSE_READY, 16'h0000);
		repeat (READY_CYC) @(negedge clk_sys);
		wr(fcs_pkg::ADDR_BANK_SEL, 16'h0007);
		rd_chk("master ready", fcs_pkg::ADDR_CRC_RESULT, 16'h0001);
		wr(fcs_pkg::ADDR_CRC_RESULT, 16'hFFFF);
		rd_chk("result kept", fcs_pkg::ADDR_CRC_RESULT, 16'h0001);
		for (int b = 0; b < 4; b++) begin
			wr(fcs_pkg::ADDR_BANK_SEL, 16'(b));
			wr(fcs_pkg::ADDR_FUSE_READY, 16'h0000);
			rd_chk("chan ready", fcs_pkg::ADDR_FUSE_READY, 16'h0001);
		end
		// one clean run, then one failing bank at a time
		for (int m = 0; m < 6; m++) begin
			fuse_defect_mask = (m == 0) ? 5'h00 : 5'(1 << (m - 1));
			wr(fcs_pkg::ADDR_BANK_SEL, 16'h0004);
			wr(fcs_pkg::ADDR_TEST_MODE, 16'h0000);
			wr(fcs_pkg::ADDR_TEST_MODE, 16'h0001);
			wr(fcs_pkg::ADDR_BANK_SEL, 16'h0007);
			// the master-bank select frame already spent 400 cycles of the wait
			repeat (fcs_pkg::CRC_DONE_CYC - 400) @(negedge clk_sys);
			rd_chk("crc result", fcs_pkg::ADDR_CRC_RESULT, 16'h00F9 & ~({11'h000, fuse_defect_mask} << 3));
		end
		results();
	end
endmodule // fcs_tb_top
